/* include/sast_pkg.sv */
// Constants, types and timing figures shared by the sequence timing block.
// Assumes a single 125 MHz clock; all intervals are counted in timebase ticks.
package sast_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timebase.
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam real         TICK_TIME_MS    = 0.1;
  localparam int unsigned TICK_CYCLES_DEF =
    int'(TICK_TIME_MS * 1.0e6 / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Interval counters.
  localparam int unsigned CNT_W = 15;
  typedef logic [CNT_W-1:0] sast_cnt_t;

  // Converts a time in milliseconds to a count of timebase ticks.
  function automatic sast_cnt_t ms_to_ticks(input real ms);
    return sast_cnt_t'(int'(ms / TICK_TIME_MS));
  endfunction

  localparam real INIT_TIME_S    = 2.0;
  localparam real RECOG_TIME_MS  = 2.0;
  localparam real MODE_TIME_MS   = 2.0;
  localparam real DETECT_TIME_MS = 0.5;
  localparam real FREE_CLR_MS    = 1.5;
  localparam real BRAKE_CLR_MS   = 80.0;

  localparam sast_cnt_t INIT_TICKS   = ms_to_ticks(INIT_TIME_S * 1000.0);
  localparam sast_cnt_t RECOG_TICKS  = ms_to_ticks(RECOG_TIME_MS);
  localparam sast_cnt_t MODE_TICKS   = ms_to_ticks(MODE_TIME_MS);
  localparam sast_cnt_t DETECT_TICKS = ms_to_ticks(DETECT_TIME_MS);
  localparam sast_cnt_t FREE_TICKS   = ms_to_ticks(FREE_CLR_MS);
  localparam sast_cnt_t BRAKE_TICKS  = ms_to_ticks(BRAKE_CLR_MS);

  ////////////////////////////////////////////////////////////////////////////
  // Sequence inputs and their fixed roles.
  localparam int unsigned NUM_SEQ         = 5;
  localparam int unsigned SEQ_SERVO_ON    = 0;
  localparam int unsigned SEQ_ALARM_RESET = 1;
  localparam int unsigned SEQ_MODE_SEL    = 2;
  localparam int unsigned STOP_ACT_W      = 3;
  localparam int unsigned STOP_FREE_BIT   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_INIT  = 4'h1,
    ST_IDLE  = 4'h2,
    ST_RUN   = 4'h4,
    ST_FAULT = 4'h8
  } sast_state_e;

  // Status reported to the host.
  typedef struct packed {
    logic servo_ctrl_ready;
    logic op_ready;
    logic alarm_detect;
    logic control_mode;
    logic mode_busy;
  } sast_status_s;

endpackage

/* core/sast_tick.sv */
// Free-running timebase: one-cycle tick every TICK_CYCLES clocks.
// Assumes the synchronous active-high reset of the sequence timing block.
`timescale 1ns/1ns
`default_nettype none
module sast_tick
  import sast_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset,
  // Timebase.
  output logic      tick
);

  localparam logic [15:0] LAST = 16'(TICK_CYCLES - 1);

  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic        next_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Divider wraps at the last count and pulses the tick there.
  always_comb
  begin
    next_tick    = (div_cnt == LAST);
    next_div_cnt = next_tick ? 16'h0000 : div_cnt + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      tick    <= next_tick;
    end
  end

  // A tick is never longer than one cycle.
  tick_pulse_a : assert property (@(posedge clk) disable iff (reset)
    tick |=> !tick) else $error("timebase tick lasted two cycles");

endmodule // sast_tick
`default_nettype wire

/* core/sast_top.sv */
// Sequence signal timing of a servo amplifier toward its host controller:
// initialisation, servo-on handshake, input recognition, mode switching
// and alarm detection and reset.
// Assumes pins are asynchronous and alarm_event comes from logic on clk.
`timescale 1ns/1ns
`default_nettype none
module sast_top
  import sast_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Sequence input pins from the host.
  input  wire logic [NUM_SEQ-1:0]    seq_in_pin,
  // Internal alarm source and stop action configuration.
  input  wire logic                  alarm_event,
  input  wire logic [STOP_ACT_W-1:0] alarm_stop_action_setting,
  // Status toward the host.
  output var  sast_status_s          status,
  output logic [NUM_SEQ-1:0]         seq_recognised,
  output logic                       brake_short_stop
);

  // True on the tick that ends an interval of the given length.
  function automatic logic timer_done(input logic run, input sast_cnt_t cnt,
                                      input sast_cnt_t limit, input logic tk);
    return run && tk && (cnt == limit - sast_cnt_t'(1));
  endfunction

  logic tick;

  sast_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser plus one history stage for edge detection.
  logic [NUM_SEQ-1:0] pin_meta, pin_sync, pin_prev;
  logic [NUM_SEQ-1:0] next_pin_meta, next_pin_sync, next_pin_prev;

  always_comb
  begin
    next_pin_meta = seq_in_pin;
    next_pin_sync = pin_meta;
    next_pin_prev = pin_sync;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end
    else
    begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
      pin_prev <= next_pin_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Recognition: a rising edge starts a 2 ms interval; at its end the input
  // is reported. A short pulse still yields at least a one-cycle report.
  logic [NUM_SEQ-1:0] rec_run, next_rec_run, next_rec, rec_fire;
  sast_cnt_t          rec_cnt [NUM_SEQ];
  sast_cnt_t          next_rec_cnt [NUM_SEQ];

  always_comb
  begin
    for (int i = 0; i < NUM_SEQ; i++)
    begin
      next_rec_run[i] = rec_run[i];
      next_rec_cnt[i] = rec_cnt[i];
      next_rec[i]     = seq_recognised[i];
      rec_fire[i]     = timer_done(rec_run[i], rec_cnt[i], RECOG_TICKS,
                                   tick);
      if (!pin_sync[i] && !rec_run[i])
        next_rec[i] = 1'b0;
      if (pin_sync[i] && !pin_prev[i])
      begin
        next_rec_run[i] = 1'b1;
        next_rec_cnt[i] = '0;
      end
      else if (rec_fire[i])
      begin
        next_rec_run[i] = 1'b0;
        next_rec[i]     = 1'b1;
      end
      else if (rec_run[i] && tick)
        next_rec_cnt[i] = rec_cnt[i] + sast_cnt_t'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rec_run        <= '0;
      seq_recognised <= '0;
      for (int i = 0; i < NUM_SEQ; i++)
        rec_cnt[i] <= '0;
    end
    else
    begin
      rec_run        <= next_rec_run;
      seq_recognised <= next_rec;
      for (int i = 0; i < NUM_SEQ; i++)
        rec_cnt[i] <= next_rec_cnt[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode switch: any change of the select level restarts the 2 ms window;
  // the new mode takes effect at its end, so bouncing only delays it.
  logic      mode_run, next_mode_run, next_mode;
  sast_cnt_t mode_cnt, next_mode_cnt;

  always_comb
  begin
    next_mode_run = mode_run;
    next_mode_cnt = mode_cnt;
    next_mode     = status.control_mode;
    if (pin_sync[SEQ_MODE_SEL] != pin_prev[SEQ_MODE_SEL])
    begin
      next_mode_run = 1'b1;
      next_mode_cnt = '0;
    end
    else if (timer_done(mode_run, mode_cnt, MODE_TICKS, tick))
    begin
      next_mode_run = 1'b0;
      next_mode     = pin_sync[SEQ_MODE_SEL];
    end
    else if (mode_run && tick)
      next_mode_cnt = mode_cnt + sast_cnt_t'(1);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_run <= 1'b0;
      mode_cnt <= '0;
    end
    else
    begin
      mode_run <= next_mode_run;
      mode_cnt <= next_mode_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm: detection 0.5 ms after the event; a recognised reset clears it
  // after 1.5 ms or 80 ms by stop action. A new alarm beats a reset.
  logic      alm_pend, next_alm_pend, next_detect;
  logic      clr_run, next_clr_run, clr_free, next_clr_free;
  sast_cnt_t alm_cnt, next_alm_cnt, clr_cnt, next_clr_cnt;
  sast_cnt_t clr_limit;

  always_comb
  begin
    next_alm_pend = alm_pend;
    next_alm_cnt  = alm_cnt;
    next_detect   = status.alarm_detect;
    next_clr_run  = clr_run;
    next_clr_cnt  = clr_cnt;
    next_clr_free = clr_free;
    clr_limit     = clr_free ? FREE_TICKS : BRAKE_TICKS;
    if (alarm_event)
    begin
      next_alm_pend = 1'b1;
      next_alm_cnt  = '0;
      next_clr_run  = 1'b0;
    end
    else
    begin
      if (timer_done(alm_pend, alm_cnt, DETECT_TICKS, tick))
      begin
        next_alm_pend = 1'b0;
        next_detect   = 1'b1;
      end
      else if (alm_pend && tick)
        next_alm_cnt = alm_cnt + sast_cnt_t'(1);
      if (rec_fire[SEQ_ALARM_RESET] && status.alarm_detect)
      begin
        next_clr_run  = 1'b1;
        next_clr_cnt  = '0;
        next_clr_free = alarm_stop_action_setting[STOP_FREE_BIT];
      end
      else if (timer_done(clr_run, clr_cnt, clr_limit, tick))
      begin
        next_clr_run = 1'b0;
        next_detect  = alm_pend;
      end
      else if (clr_run && tick)
        next_clr_cnt = clr_cnt + sast_cnt_t'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      alm_pend         <= 1'b0;
      alm_cnt          <= '0;
      clr_run          <= 1'b0;
      clr_cnt          <= '0;
      clr_free         <= 1'b0;
      brake_short_stop <= 1'b0;
    end
    else
    begin
      alm_pend         <= next_alm_pend;
      alm_cnt          <= next_alm_cnt;
      clr_run          <= next_clr_run;
      clr_cnt          <= next_clr_cnt;
      clr_free         <= next_clr_free;
      brake_short_stop <= next_clr_run && !next_clr_free;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: initialisation, then the servo-on handshake. A servo-on still
  // recognised when initialisation ends is accepted at once; the host must wait for ready.
  sast_state_e  state, next_state;
  sast_cnt_t    init_cnt, next_init_cnt;
  sast_status_s next_status;

  always_comb
  begin
    next_state    = state;
    next_init_cnt = init_cnt;
    case (state)
      ST_INIT:
        if (timer_done(1'b1, init_cnt, INIT_TICKS, tick))
          next_state = ST_IDLE;
        else if (tick)
          next_init_cnt = init_cnt + sast_cnt_t'(1);
      ST_IDLE:
        if (status.alarm_detect)
          next_state = ST_FAULT;
        else if (seq_recognised[SEQ_SERVO_ON])
          next_state = ST_RUN;
      ST_RUN:
        if (status.alarm_detect)
          next_state = ST_FAULT;
        else if (!seq_recognised[SEQ_SERVO_ON])
          next_state = ST_IDLE;
      ST_FAULT:
        if (!status.alarm_detect)
          next_state = ST_IDLE;
      default:
        next_state = ST_INIT;
    endcase
    next_status.servo_ctrl_ready = (next_state != ST_INIT);
    next_status.op_ready         = (next_state == ST_RUN);
    next_status.alarm_detect     = next_detect;
    next_status.control_mode     = next_mode;
    next_status.mode_busy        = next_mode_run;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state    <= ST_INIT;
      init_cnt <= '0;
      status   <= '0;
    end
    else
    begin
      state    <= next_state;
      init_cnt <= next_init_cnt;
      status   <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the timing relations.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence reset_accepted;
    rec_fire[SEQ_ALARM_RESET] && status.alarm_detect && !alarm_event;
  endsequence
  sequence clear_armed;
    clr_run && (clr_cnt == '0);
  endsequence

  init_time_a : assert property (
    $rose(status.servo_ctrl_ready) |-> $past(init_cnt) == INIT_TICKS - 1)
    else $error("control ready rose before full init count");
  ready_gate_a : assert property (
    (state == ST_INIT) |=> !status.servo_ctrl_ready || $past(tick))
    else $error("control ready shown during initialisation");
  op_ready_a : assert property (
    $rose(status.op_ready) |-> $past(seq_recognised[SEQ_SERVO_ON])
                             && status.servo_ctrl_ready)
    else $error("operation ready without accepted servo-on");
  recog_time_a : assert property (
    $rose(seq_recognised[SEQ_SERVO_ON]) |->
      $past(rec_cnt[SEQ_SERVO_ON]) == RECOG_TICKS - 1 && $past(tick))
    else $error("servo-on recognised at wrong time");
  mode_time_a : assert property (
    $changed(status.control_mode) |-> $past(mode_cnt) == MODE_TICKS - 1
                                    && $past(tick) && !status.mode_busy)
    else $error("control mode changed off the 2 ms boundary");
  alarm_detect_a : assert property (
    $rose(status.alarm_detect) |-> $past(alm_cnt) == DETECT_TICKS - 1)
    else $error("alarm detection at wrong delay");
  free_clear_a : assert property (
    $fell(status.alarm_detect) && $past(clr_free) |->
      $past(clr_cnt) == FREE_TICKS - 1)
    else $error("free-run alarm clear at wrong delay");
  brake_clear_a : assert property (
    $fell(status.alarm_detect) && !$past(clr_free) |->
      $past(clr_cnt) == BRAKE_TICKS - 1 && $past(brake_short_stop))
    else $error("brake-stop alarm clear at wrong delay");
  clear_start_a : assert property (
    reset_accepted |=> clear_armed)
    else $error("alarm reset interval did not restart");

endmodule // sast_top
`default_nettype wire

/* verif/sast_host.sv */
// Host controller model that drives the sequence pins of the block.
// Assumes the test sets the wanted pin levels on req at rising clk edges.
`timescale 1ns/1ns
`default_nettype none
module sast_host
  import sast_pkg::*;
#(
  parameter int unsigned HOLD_CYC  = 20,
  parameter int unsigned MODE_WAIT = 44
)
(
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               reset,
  // Wanted levels and device status.
  input  wire logic [NUM_SEQ-1:0] req,
  input  wire sast_status_s       status,
  // Pins toward the device.
  output logic [NUM_SEQ-1:0]      seq_in_pin
);
  logic motor_on;
  logic want;
  int   held [NUM_SEQ];
  int   mwait;

  initial seq_in_pin = '0;

  ////////////////////////////////////////////////////////////////////////////
  // The host keeps its side of the handshake, whatever the test asks.
  always @(posedge clk)
  begin
    if (reset)
    begin
      motor_on <= 1'b0;
      seq_in_pin <= '0;
      mwait <= 0;
      foreach (held[i]) held[i] <= 0;
    end
    else
    begin
      motor_on <= motor_on | status.servo_ctrl_ready;
      for (int i = 0; i < NUM_SEQ; i++)
      begin
        want = req[i];
        if (i == SEQ_SERVO_ON)
          want = want & motor_on & status.servo_ctrl_ready;
        if (i == SEQ_MODE_SEL && !status.op_ready)
          want = seq_in_pin[i];
        if (i != SEQ_MODE_SEL && mwait != 0 && !seq_in_pin[i])
          want = 1'b0;
        // A short pulse could be missed, so each one is stretched.
        if (seq_in_pin[i] && held[i] < HOLD_CYC)
          want = 1'b1;
        seq_in_pin[i] <= want;
        held[i] <= want ? held[i] + 1 : 0;
        if (i == SEQ_MODE_SEL)
          mwait <= (want != seq_in_pin[i]) ? int'(MODE_WAIT) :
                   (mwait > 0 ? mwait - 1 : 0);
      end
    end
  end
endmodule // sast_host
`default_nettype wire

/* verif/sast_top_test.sv */
// Self-checking bench of the sequence timing block with the host model.
// Assumes a short timebase so that the 2.0 s start-up fits the run.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
  err_total++; $display("unexpected %s: expected %h, seen %h", nm, ex, gt); \
  end end
module sast_top_test;
  import sast_pkg::*;
  localparam int TC  = 2;
  localparam int LIM = 60000;
  typedef struct { logic [9:0] v; int lo; int hi; string nm; } sast_note_s;

  logic               clk;
  logic               reset;
  logic [NUM_SEQ-1:0] req;
  logic [NUM_SEQ-1:0] pins;
  logic               alarm_event;
  logic [2:0]         stop;
  sast_status_s       status;
  logic [NUM_SEQ-1:0] recog;
  logic               brake;
  logic [9:0]         exp_v;
  logic [9:0]         cur;
  logic [9:0]         prev;
  sast_note_s         q[$];
  sast_note_s         n;
  int                 cyc;
  int                 b;
  int                 len;
  int                 nclr;
  int                 err_total;
  int                 comparisons;

  always #4 clk = ~clk;

  sast_host #(.HOLD_CYC(10 * TC), .MODE_WAIT(20 * TC + 4)) host (
    .clk(clk), .reset(reset), .req(req), .status(status),
    .seq_in_pin(pins));

  sast_top #(.TICK_CYCLES(TC)) dut (
    .clk(clk), .reset(reset), .seq_in_pin(pins),
    .alarm_event(alarm_event), .alarm_stop_action_setting(stop),
    .status(status), .seq_recognised(recog), .brake_short_stop(brake));

  ////////////////////////////////////////////////////////////////////////////
  // Each change of the status or recognition outputs must be the oldest note, in its window.
  always @(posedge clk)
  begin
    #1;
    cyc++;
    cur = {status, recog};
    if (!reset && cur !== prev)
    begin
      if (q.size() == 0) `CHK("spurious change", prev, cur)
      else
      begin
        n = q.pop_front();
        `CHK(n.nm, n.v, cur)
        `CHK({n.nm, " time"}, 1'b1, (cyc >= n.lo && cyc <= n.hi))
      end
    end
    prev = cur;
  end

  // Notes the expected output vector with its window of cycles.
  task automatic push(input int lo, input int hi, input string nm);
    q.push_back('{exp_v, lo, hi, nm});
  endtask

  // Waits, with a bound, until few enough results are outstanding.
  task automatic wait_q(input int lim);
    int k;
    k = 0;
    while (q.size() > lim && k < LIM)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= LIM)
    begin
      err_total++;
      $display("unexpected wait: %0d results missing", q.size());
      conclude();
    end
  endtask

  // A pulse on one pin, shorter than the recognition time.
  task automatic pulse(input int i);
    len = 20 + $urandom % 11;
    @(posedge clk);
    req[i] <= 1'b1;
    b = cyc + 1;
    exp_v[i] = 1'b1;
    push(b + 19 * TC + 2, b + 20 * TC + 9, "pin seen");
    exp_v[i] = 1'b0;
    push(b + 19 * TC + 3, b + 20 * TC + 10, "pin pulse");
    repeat (len) @(posedge clk);
    req[i] <= 1'b0;
  endtask

  task automatic conclude();
    $display("comparisons %0d, err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Start-up, inputs, mode changes, then an alarm for each stop action.
  initial
  begin
    len = $urandom(32'h83c6);
    {clk, alarm_event, stop, req, exp_v, prev} = '0;
    {cyc, err_total, comparisons} = '0;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    req <= 5'h01;
    b = cyc + 1;
    exp_v[9] = 1'b1;
    push(b + 19999 * TC, b + 20000 * TC + 4, "ctrl ready");
    wait_q(0);
    b = cyc + 1;
    exp_v[0] = 1'b1;
    push(b + 19 * TC + 2, b + 20 * TC + 9, "servo-on seen");
    exp_v[8] = 1'b1;
    push(b + 19 * TC + 4, b + 20 * TC + 11, "op ready");
    wait_q(0);
    pulse(3);
    wait_q(0);
    pulse(4);
    wait_q(0);
    for (int m = 1; m >= 0; m--)
    begin
      @(posedge clk);
      req[SEQ_MODE_SEL] <= m[0];
      b = cyc + 1;
      // The select pin is a sequence input as well, so its recognition
      // bit drops with the busy flag and rises with the new mode.
      exp_v[5] = 1'b1;
      exp_v[SEQ_MODE_SEL] = 1'b0;
      push(b + 3, b + 5, "mode busy");
      exp_v[6] = m[0];
      exp_v[5] = 1'b0;
      exp_v[SEQ_MODE_SEL] = m[0];
      push(b + 19 * TC + 2, b + 20 * TC + 9, "mode done");
      wait_q(0);
    end
    for (int s = 0; s < 8; s++)
    begin
      repeat ($urandom % 8 + 1) @(posedge clk);
      stop <= 3'(s);
      alarm_event <= 1'b1;
      b = cyc + 1;
      @(posedge clk);
      alarm_event <= 1'b0;
      exp_v[7] = 1'b1;
      push(b + 4 * TC, b + 5 * TC + 3, "alarm detect");
      exp_v[8] = 1'b0;
      push(b + 4 * TC + 1, b + 5 * TC + 4, "op drop");
      wait_q(0);
      nclr = (s % 2 == 1) ? 15 : 800;
      pulse(SEQ_ALARM_RESET);
      exp_v[7] = 1'b0;
      push(b + (18 + nclr) * TC, b + (20 + nclr) * TC + 11,
           "alarm clear");
      exp_v[8] = 1'b1;
      push(b + (18 + nclr) * TC + 1, b + (20 + nclr) * TC + 14, "op back");
      wait_q(2);
      repeat (10) @(posedge clk);
      `CHK("brake stop", ((s % 2 == 0) ? 1'b1 : 1'b0), brake)
      wait_q(0);
    end
    // A reset request with no alarm present must change no status.
    pulse(SEQ_ALARM_RESET);
    wait_q(0);
    @(posedge clk);
    req <= '0;
    b = cyc + 1;
    exp_v[0] = 1'b0;
    push(b + 3, b + 6, "servo-on off");
    exp_v[8] = 1'b0;
    push(b + 4, b + 8, "op off");
    wait_q(0);
    repeat (100) @(posedge clk);
    conclude();
  end
endmodule // sast_top_test
`default_nettype wire
